// *** src/mccd_oneshot.sv ***
// one-shot pulse timer for a general output pin
// assumes a single clock domain; start is a one-cycle pulse
`timescale 1ns/10ps
module mccd_oneshot #(
    parameter int WIDTH_CYC = 2_400_000 // pulse length in clocks
) (
    input  wire logic clk_i,     // system clock
    input  wire logic reset_n_i, // async reset, active low
    input  wire logic clear_i,   // soft reset, synchronous
    input  wire logic start_i,   // start or restart pulse
    output logic      busy_o     // high while pulse runs
);
    localparam int CW = $clog2(WIDTH_CYC + 1);
    logic [CW-1:0] cnt_q; // remaining cycles

    // restart wins over running; a retrigger stretches the pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else if (clear_i) begin
            cnt_q <= '0;
        end else if (start_i) begin
            cnt_q <= CW'(WIDTH_CYC);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    assign busy_o = (cnt_q != '0);
endmodule : mccd_oneshot

// *** src/mccd_pkg.sv ***
// package for the motion control command decoder
// assumes one 100 MHz clock and an Avalon-MM slave of 32-bit words
package mccd_pkg;
    // avalon word offsets (byte addresses)
    localparam logic [3:0]  OFS_CMD      = 4'h0; // command byte, write
    localparam logic [3:0]  OFS_PINCFG   = 4'h4; // pin 0/1 mode and polarity
    localparam logic [3:0]  OFS_OUTPUT   = 4'h8; // output bits, read
    localparam logic [3:0]  OFS_STATUS   = 4'hC; // status bits, read
    localparam logic [3:0]  OFS_DECODE   = 4'h0; // last decode, read
    // pin configuration fields: mode[1:0], pol[2] for pin 0; +4 for pin 1
    localparam int          PCFG_STRIDE  = 4;
    localparam int          PCFG_POL     = 2;
    localparam logic [1:0]  MODE_GPO     = 2'b01; // general output
    localparam logic [1:0]  MODE_ONESHOT = 2'b11; // one-shot output
    localparam logic [7:0]  PINCFG_RST   = 8'h11; // both pins general output
    localparam logic [7:0]  OUT_RST      = 8'h00; // output bits after reset
    localparam logic [3:0]  CND_ERC_WAIT = 4'b0101; // deviation-clear wait
    localparam logic [3:0]  CND_IDLE     = 4'b0000; // condition at rest
    // command codes
    localparam logic [7:0]  CMD_NOP      = 8'h00;
    localparam logic [7:0]  CMD_SOFT_RESET_CMD     = 8'h04;
    localparam logic [7:0]  CMD_OUT_CLR  = 8'h10; // 10h..17h
    localparam logic [7:0]  CMD_OUT_SET  = 8'h18; // 18h..1Fh
    localparam logic [7:0]  CMD_CNT_CLR  = 8'h20; // 20h..23h
    localparam logic [7:0]  CMD_DEV_ON   = 8'h24;
    localparam logic [7:0]  CMD_DEV_OFF  = 8'h25;
    localparam logic [7:0]  CMD_PRE_CAN  = 8'h26;
    localparam logic [7:0]  CMD_C5_CAN   = 8'h27;
    localparam logic [7:0]  CMD_POS_STA  = 8'h28;
    localparam logic [7:0]  CMD_LATCH    = 8'h29;
    localparam logic [7:0]  CMD_PRE_SHF  = 8'h2B;
    localparam logic [7:0]  CMD_C5_SHF   = 8'h2C;
    localparam logic [7:0]  CMD_EVT_CLR  = 8'h2D;
    localparam logic [7:0]  CMD_ERR_CLR  = 8'h2E;
    localparam logic [7:0]  CMD_COMMIT   = 8'h4F;
    localparam logic [7:0]  CMD_PRE2_WR  = 8'h80; // 80h.. second stage write
    localparam logic [7:0]  CMD_REG_WR   = 8'h90; // 90h.. register write
    localparam logic [7:0]  CMD_PRE2_RD  = 8'hC0; // C0h.. second stage read
    localparam logic [7:0]  CMD_REG_RD   = 8'hD0; // D0h.. register read
    localparam logic [7:0]  REG_LAST     = 8'hFF; // last read code
    // decode kinds reported on the register-access port
    localparam logic [1:0]  ACC_NONE     = 2'b00;
    localparam logic [1:0]  ACC_REG      = 2'b01;
    localparam logic [1:0]  ACC_PRE2     = 2'b10;
    // timing
    localparam int          CLK_HZ       = 100_000_000;
    localparam int          ONESHOT_US   = 24_000; // middle of 23..25 ms
    localparam int          ONESHOT_CYC  = ONESHOT_US * (CLK_HZ / 1_000_000);
    localparam int          SOFT_RESET_CMD_CYC     = 12; // host quiet time in clocks
endpackage : mccd_pkg

// *** src/mccd_top.sv ***
// command decoder for one axis of a pulse-train motion controller
// assumes an Avalon-MM master on clk_i; side effects other than pin, deviation clear, condition and flag levels leave as pulses
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module mccd_top
    import mccd_pkg::*;
#(
    parameter int ONESHOT_CYCLES = mccd_pkg::ONESHOT_CYC // pulse clocks
) (
    input  wire logic        clk_i,              // 100 MHz clock
    input  wire logic        reset_n_i,          // async reset, low
    input  wire logic [3:0]  avs_address_i,      // byte address
    input  wire logic        avs_read_i,         // read strobe
    input  wire logic        avs_write_i,        // write strobe
    input  wire logic [31:0] avs_writedata_i,    // write data
    input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
    output logic [31:0]      avs_readdata_o,     // read data
    output logic             avs_waitrequest_o,  // stall
    input  wire logic        override2_mode_i,   // target override 2 on
    input  wire logic        event_irq_set_i,    // event source pulse
    input  wire logic        error_irq_set_i,    // error source pulse
    input  wire logic        dev_wait_done_i,    // deviation wait over
    output logic [7:0]       out_pin_o,          // general output pins
    output logic             soft_reset_o,       // reset pulse to axis
    output logic [3:0]       counter_clear_o,    // clear pulse per counter
    output logic             deviation_clear_output_o, // servo pin
    output logic [3:0]       axis_condition_code_o,    // wait condition
    output logic             preload_cancel_all_o,  // cancel pulse
    output logic             cmp5_preload_cancel_o, // cancel pulse
    output logic             preload_shift_all_o,   // shift pulse
    output logic             cmp5_preload_shift_o,  // shift pulse
    output logic             override_commit_o,     // commit pulse
    output logic             position_start_o,      // start pulse
    output logic             counter_latch_o,       // latch pulse
    output logic             event_irq_flag_o,      // status flag
    output logic             error_irq_flag_o,      // status flag
    output logic             reg_access_o,          // access pulse
    output logic             reg_access_write_o,    // 1 write, 0 read
    output logic [1:0]       reg_access_kind_o,     // register or pre2
    output logic [5:0]       reg_access_index_o     // register index
);
    import mccd_pkg::*;

    // field helpers used for both one-shot pins
    function automatic logic [1:0] pin_mode(input logic [7:0] cfg,
                                            input int pin);
        pin_mode = cfg[pin*PCFG_STRIDE +: 2];
    endfunction : pin_mode

    function automatic logic pin_pol(input logic [7:0] cfg, input int pin);
        pin_pol = cfg[pin*PCFG_STRIDE + PCFG_POL];
    endfunction : pin_pol

    // read commands exist for a few holes-free ranges only
    function automatic logic reg_readable(input logic [7:0] c);
        reg_readable = (c <= 8'hF6) || (c == 8'hFC) ||
                       (c == 8'hFD) || (c == REG_LAST);
    endfunction : reg_readable

    logic       req_q;          // read answer pending
    logic       cmd_wr;         // command write this cycle
    logic [7:0] cmd;            // command byte
    logic       soft_reset_cmd_pend_q;    // soft reset issued last cycle
    logic [7:0] pincfg_q;       // one-shot configuration
    logic [7:0] out_bits_q;     // general output bits
    logic [1:0] os_start;       // one-shot triggers
    logic [1:0] os_busy;        // one-shot active
    logic       ev_clr;         // event flag clear
    logic       er_clr;         // error flag clear
    logic       acc_hit;        // decoded register access
    logic       acc_wr;         // direction of access
    logic [1:0] acc_kind;       // kind of access
    logic [5:0] acc_idx;        // index of access
    logic [7:0] last_cmd_q;     // last accepted command

    assign cmd_wr = avs_write_i && (avs_address_i == OFS_CMD) &&
                    avs_byteenable_i[0];
    assign cmd    = avs_writedata_i[7:0];

    // writes finish in one cycle, reads wait one cycle for registered data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_q <= 1'b0;
        end else begin
            req_q <= avs_read_i && !req_q;
        end
    end
    assign avs_waitrequest_o = avs_read_i && !req_q;

    // read mux; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !req_q) begin
            unique case (avs_address_i)
                OFS_PINCFG: avs_readdata_o <= {24'h0, pincfg_q};
                OFS_OUTPUT: avs_readdata_o <= {24'h0, out_pin_o};
                OFS_STATUS: avs_readdata_o <= {26'h0, error_irq_flag_o,
                    event_irq_flag_o, axis_condition_code_o};
                OFS_DECODE: avs_readdata_o <= {24'h0, last_cmd_q};
                default:    avs_readdata_o <= '0;
            endcase
        end
    end

    // soft reset is applied one cycle after the command, from a register,
    // so the bus handshake of the command itself still completes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            soft_reset_cmd_pend_q <= 1'b0;
        end else begin
            soft_reset_cmd_pend_q <= cmd_wr && (cmd == CMD_SOFT_RESET_CMD);
        end
    end

    // pin configuration register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pincfg_q <= PINCFG_RST;
        end else if (soft_reset_cmd_pend_q) begin
            pincfg_q <= PINCFG_RST;
        end else if (avs_write_i && avs_address_i == OFS_PINCFG &&
                     avs_byteenable_i[0]) begin
            pincfg_q <= avs_writedata_i[7:0];
        end
    end

    // output bits: clear and set commands, one bit each
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_bits_q <= OUT_RST;
        end else if (soft_reset_cmd_pend_q) begin
            out_bits_q <= OUT_RST;
        end else if (cmd_wr && cmd[7:3] == CMD_OUT_CLR[7:3]) begin
            out_bits_q[cmd[2:0]] <= 1'b0;
        end else if (cmd_wr && cmd[7:3] == CMD_OUT_SET[7:3]) begin
            out_bits_q[cmd[2:0]] <= 1'b1;
        end
    end

    // one-shot triggers on pins 0 and 1
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            os_start[p] = cmd_wr && pin_mode(pincfg_q, p) == MODE_ONESHOT &&
                ((!pin_pol(pincfg_q, p) && cmd == CMD_OUT_CLR + 8'(p)) ||
                 (pin_pol(pincfg_q, p) && cmd == CMD_OUT_SET + 8'(p)));
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_os
        mccd_oneshot #(
            .WIDTH_CYC (ONESHOT_CYCLES)
        ) u_os (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .clear_i   (soft_reset_cmd_pend_q),
            .start_i   (os_start[g]),
            .busy_o    (os_busy[g])
        );
    end

    // pin drive: one-shot pins idle at the inverse of their polarity
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_pin_o <= OUT_RST;
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (p < 2 && pin_mode(pincfg_q, p) == MODE_ONESHOT) begin
                    out_pin_o[p] <= os_busy[p] ~^ pin_pol(pincfg_q, p);
                end else begin
                    out_pin_o[p] <= out_bits_q[p];
                end
            end
        end
    end

    // one-cycle command pulses; anything unlisted yields none
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            soft_reset_o          <= 1'b0;
            counter_clear_o       <= '0;
            preload_cancel_all_o  <= 1'b0;
            cmp5_preload_cancel_o <= 1'b0;
            preload_shift_all_o   <= 1'b0;
            cmp5_preload_shift_o  <= 1'b0;
            override_commit_o     <= 1'b0;
            position_start_o      <= 1'b0;
            counter_latch_o       <= 1'b0;
        end else begin
            soft_reset_o          <= cmd_wr && cmd == CMD_SOFT_RESET_CMD;
            for (int k = 0; k < 4; k++) begin
                counter_clear_o[k] <= cmd_wr &&
                    cmd == CMD_CNT_CLR + 8'(k);
            end
            preload_cancel_all_o  <= cmd_wr && cmd == CMD_PRE_CAN;
            cmp5_preload_cancel_o <= cmd_wr && cmd == CMD_C5_CAN;
            preload_shift_all_o   <= cmd_wr && cmd == CMD_PRE_SHF;
            cmp5_preload_shift_o  <= cmd_wr && cmd == CMD_C5_SHF;
            override_commit_o     <= cmd_wr && cmd == CMD_COMMIT;
            position_start_o      <= cmd_wr && cmd == CMD_POS_STA &&
                                     override2_mode_i;
            counter_latch_o       <= cmd_wr && cmd == CMD_LATCH;
        end
    end

    // deviation clear output and its wait condition
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            deviation_clear_output_o <= 1'b0;
            axis_condition_code_o    <= CND_IDLE;
        end else if (soft_reset_cmd_pend_q) begin
            deviation_clear_output_o <= 1'b0;
            axis_condition_code_o    <= CND_IDLE;
        end else if (cmd_wr && cmd == CMD_DEV_OFF) begin
            deviation_clear_output_o <= 1'b0;
            axis_condition_code_o    <= CND_IDLE;
        end else if (cmd_wr && cmd == CMD_DEV_ON) begin
            deviation_clear_output_o <= 1'b1;
            axis_condition_code_o    <= CND_ERC_WAIT;
        end else if (dev_wait_done_i) begin
            axis_condition_code_o    <= CND_IDLE;
        end
    end

    assign ev_clr = cmd_wr && cmd == CMD_EVT_CLR;
    assign er_clr = cmd_wr && cmd == CMD_ERR_CLR;

    // interrupt flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_irq_flag_o <= 1'b0;
            error_irq_flag_o <= 1'b0;
        end else if (soft_reset_cmd_pend_q) begin
            event_irq_flag_o <= 1'b0;
            error_irq_flag_o <= 1'b0;
        end else begin
            event_irq_flag_o <= event_irq_set_i ||
                                (event_irq_flag_o && !ev_clr);
            error_irq_flag_o <= error_irq_set_i ||
                                (error_irq_flag_o && !er_clr);
        end
    end

    // register access decode; all writes land in the second stage
    always_comb begin
        acc_hit  = 1'b0;
        acc_wr   = 1'b0;
        acc_kind = ACC_NONE;
        acc_idx  = cmd[5:0];
        if (cmd >= CMD_REG_RD) begin
            acc_hit  = reg_readable(cmd);
            acc_kind = ACC_REG;
            acc_idx  = 6'(cmd - CMD_REG_RD);
        end else if (cmd >= CMD_PRE2_RD) begin
            acc_hit  = (cmd <= 8'hCC);
            acc_kind = ACC_PRE2;
            acc_idx  = 6'(cmd - CMD_PRE2_RD);
        end else if (cmd >= CMD_REG_WR) begin
            acc_hit  = (cmd <= 8'hAC) || cmd == 8'hB2 || cmd == 8'hB3 ||
                       cmd == 8'hBC;
            acc_wr   = 1'b1;
            acc_kind = ACC_PRE2;
            acc_idx  = 6'(cmd - CMD_REG_WR);
        end else if (cmd >= CMD_PRE2_WR) begin
            acc_hit  = (cmd <= 8'h8C);
            acc_wr   = 1'b1;
            acc_kind = ACC_PRE2;
            acc_idx  = 6'(cmd - CMD_PRE2_WR);
        end
    end

    // access pulse and its qualifiers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_access_o       <= 1'b0;
            reg_access_write_o <= 1'b0;
            reg_access_kind_o  <= ACC_NONE;
            reg_access_index_o <= '0;
        end else begin
            reg_access_o <= cmd_wr && acc_hit;
            if (cmd_wr && acc_hit) begin
                reg_access_write_o <= acc_wr;
                reg_access_kind_o  <= acc_kind;
                reg_access_index_o <= acc_idx;
            end
        end
    end

    // last command byte, NOP included, for software readback
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_cmd_q <= CMD_NOP;
        end else if (cmd_wr) begin
            last_cmd_q <= cmd;
        end
    end
endmodule : mccd_top

// *** test/mccd_axis_model.sv ***
// axis-side model: status event sources and the override mode level
// assumes bench requests change just after a clk_i edge
`timescale 1ns/10ps
module mccd_axis_model (
    input  wire logic clk_i,     // clock
    input  wire logic reset_n_i, // reset, low
    input  wire logic evt_req_i, // raise an event
    input  wire logic err_req_i, // raise an error
    input  wire logic ovr_req_i, // override mode 2 wanted
    output logic      evt_set_o, // event source pulse
    output logic      err_set_o, // error source pulse
    output logic      ovr_mode_o // override mode level
);
    // registered, so sources change only after an edge like real logic
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {evt_set_o, err_set_o, ovr_mode_o} <= 3'b000;
        end else begin
            {evt_set_o, err_set_o, ovr_mode_o} <=
                {evt_req_i, err_req_i, ovr_req_i};
        end
    end
endmodule : mccd_axis_model

// *** test/mccd_sva.sv ***
// checker for the command decoder: timing of command side effects
// assumes bind onto mccd_top, one clock and an async low reset
`timescale 1ns/10ps
module mccd_sva
    import mccd_pkg::*;
(
    input wire logic        clk_i,                    // clock
    input wire logic        reset_n_i,                // reset, low
    input wire logic [3:0]  avs_address_i,            // byte address
    input wire logic        avs_write_i,              // write strobe
    input wire logic [31:0] avs_writedata_i,          // write data
    input wire logic [3:0]  avs_byteenable_i,         // lanes
    input wire logic        avs_waitrequest_o,        // stall
    input wire logic        override2_mode_i,         // override mode 2
    input wire logic [7:0]  out_pin_o,                // pins
    input wire logic [3:0]  counter_clear_o,          // clear pulses
    input wire logic        deviation_clear_output_o, // servo pin
    input wire logic [3:0]  axis_condition_code_o,    // condition
    input wire logic        position_start_o,         // start pulse
    input wire logic        counter_latch_o,          // latch pulse
    input wire logic        event_irq_flag_o          // event flag
);
    logic       cmd_wr; // command byte taken at this edge
    logic [7:0] code;   // the command byte itself
    // lane 0 must be on, else the byte never reaches the decoder
    assign cmd_wr = avs_write_i && !avs_waitrequest_o
                    && avs_address_i == OFS_CMD && avs_byteenable_i[0];
    assign code = avs_writedata_i[7:0];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // pins move two edges after the command, so windows end at 3
    chk_set_pin7: assert property (
        cmd_wr && code == 8'h1F |-> ##[1:3] out_pin_o[7])
        else $error("pin 7 did not rise after its set command");
    chk_clr_pin7: assert property (
        cmd_wr && code == 8'h17 |-> ##[1:3] !out_pin_o[7])
        else $error("pin 7 did not fall after its clear command");
    chk_cnt1_clear: assert property (
        cmd_wr && code == CMD_CNT_CLR |-> ##[1:2] counter_clear_o == 4'h1)
        else $error("counter 1 clear pulse missing or not alone");
    chk_dev_assert: assert property (
        cmd_wr && code == CMD_DEV_ON |-> ##[1:3] deviation_clear_output_o)
        else $error("deviation clear not asserted");
    chk_dev_release: assert property (
        cmd_wr && code == CMD_DEV_OFF |-> ##[1:3]
        (!deviation_clear_output_o && axis_condition_code_o == CND_IDLE))
        else $error("deviation clear not released or wait kept");
    chk_start_gated: assert property (
        cmd_wr && code == CMD_POS_STA && !override2_mode_i
        |-> ##1 !position_start_o [*3])
        else $error("start pulse outside override mode 2");
    chk_latch_once: assert property (
        cmd_wr && code == CMD_LATCH |-> ##[1:2] counter_latch_o
        ##1 !counter_latch_o)
        else $error("latch pulse missing or longer than a cycle");
    chk_evt_clear: assert property (
        cmd_wr && code == CMD_EVT_CLR |-> ##[1:3] !event_irq_flag_o)
        else $error("event flag not cleared");
    cover property (cmd_wr && code == CMD_POS_STA && override2_mode_i);
    cover property (cmd_wr && code == CMD_SOFT_RESET_CMD);
    cover property ($rose(out_pin_o[0]));
endmodule : mccd_sva

bind mccd_top mccd_sva u_sva (.*);

// *** test/mccd_top_test.sv ***
// self-checking bench for the command decoder
// assumes the design, its checker and the axis model compile first
`timescale 1ns/10ps
module mccd_top_test
    import mccd_pkg::*;
;
    localparam int N = 48; // short one-shot keeps the run brief
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, q;
    logic        avs_waitrequest_o, ovr, evt_set, err_set, wt;
    logic        evt_rq = 1'b0, err_rq = 1'b0, ovr_rq = 1'b0;
    logic [7:0]  out_pin_o;
    logic [3:0]  cnd, clr;
    logic        soft_reset_cmd, dev, pca, c5c, psh, c5s, cmt, pst, lat, evf, erf;
    logic        acc, accw;
    logic [1:0]  acck;
    logic [5:0]  acci;
    logic [12:0] s;
    int          h, n, err_total = 0, num_checks = 0;
    // all pulse outputs side by side, counter 1 clear at bit 8
    wire  [12:0] pv = {soft_reset_cmd, clr, pca, c5c, psh, c5s, cmt, pst, lat, acc};
    always #5 clk_i = ~clk_i;
    mccd_top #(.ONESHOT_CYCLES(N)) DUT (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .override2_mode_i(ovr), .event_irq_set_i(evt_set),
        .error_irq_set_i(err_set), .dev_wait_done_i(1'b0),
        .out_pin_o(out_pin_o), .soft_reset_o(soft_reset_cmd), .counter_clear_o(clr),
        .deviation_clear_output_o(dev), .axis_condition_code_o(cnd),
        .preload_cancel_all_o(pca), .cmp5_preload_cancel_o(c5c),
        .preload_shift_all_o(psh), .cmp5_preload_shift_o(c5s),
        .override_commit_o(cmt), .position_start_o(pst),
        .counter_latch_o(lat), .event_irq_flag_o(evf),
        .error_irq_flag_o(erf), .reg_access_o(acc),
        .reg_access_write_o(accw), .reg_access_kind_o(acck),
        .reg_access_index_o(acci));
    mccd_axis_model u_axis (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .evt_req_i(evt_rq), .err_req_i(err_rq), .ovr_req_i(ovr_rq),
        .evt_set_o(evt_set), .err_set_o(err_set), .ovr_mode_o(ovr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one transfer, held until waitrequest is sampled low at an edge
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(negedge clk_i);
            q = avs_readdata_o;
            wt = avs_waitrequest_o;
            @(posedge clk_i);
        end while (wt !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    // a command, then the pulses of the next five cycles gathered up
    task automatic cmdw(input logic [7:0] c);
        bus(OFS_CMD, 1'b1, {24'h0, c});
        s = '0;
        h = 0;
        repeat (5) begin
            @(negedge clk_i);
            s |= pv;
            h += int'(pv != '0);
        end
        @(posedge clk_i);
    endtask : cmdw
    // cycles that pin b spends at level v
    task automatic width(input int b, input logic v);
        n = 0;
        repeat (N + 20) begin
            @(posedge clk_i);
            n += int'(out_pin_o[b] === v);
        end
    endtask : width
    task automatic raise();
        evt_rq <= 1'b1;
        err_rq <= 1'b1;
        @(posedge clk_i);
        evt_rq <= 1'b0;
        err_rq <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : raise
    task automatic t_pins();
        for (int i = 0; i < 8; i++) begin
            cmdw(CMD_OUT_SET + 8'(i));
            chk(out_pin_o, 8'hFF >> (7 - i));
        end
        bus(OFS_OUTPUT, 1'b0, 32'h0);
        chk(q, 32'hFF);
        for (int i = 0; i < 8; i++) begin
            cmdw(CMD_OUT_CLR + 8'(i));
            chk(out_pin_o, 8'(8'hFE << i));
        end
    endtask : t_pins
    task automatic t_oneshot();
        bus(OFS_PINCFG, 1'b1, 32'h37); // pin 0 high pulse, pin 1 low pulse
        repeat (3) @(posedge clk_i);
        chk(out_pin_o[1:0], 2'b10);
        bus(OFS_CMD, 1'b1, {24'h0, CMD_OUT_SET});
        width(0, 1'b1);
        chk(n >= N - 2 && n <= N + 2, 1'b1);
        bus(OFS_CMD, 1'b1, {24'h0, CMD_OUT_CLR + 8'h01});
        width(1, 1'b0);
        chk(n >= N - 2 && n <= N + 2, 1'b1);
        bus(OFS_CMD, 1'b1, {24'h0, CMD_OUT_CLR}); // wrong edge: no pulse
        width(0, 1'b1);
        chk(n, 0);
    endtask : t_oneshot
    task automatic t_pulses();
        logic [7:0]  c [12] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h26, 8'h27,
                                8'h2B, 8'h2C, 8'h4F, 8'h29, 8'h00, 8'h3F};
        logic [12:0] e [12] = '{13'h100, 13'h200, 13'h400, 13'h800, 13'h80,
            13'h40, 13'h20, 13'h10, 13'h8, 13'h2, 13'h0, 13'h0};
        logic [7:0]  p;
        p = out_pin_o;
        for (int i = 0; i < 12; i++) begin
            cmdw(c[i]);
            chk(s, e[i]);
            chk(h, int'(e[i] != 0));
            chk(out_pin_o, p);
        end
        cmdw(CMD_POS_STA);
        chk(s, 13'h0);
        ovr_rq <= 1'b1;
        repeat (2) @(posedge clk_i);
        cmdw(CMD_POS_STA);
        chk(s, 13'h4);
        ovr_rq <= 1'b0;
    endtask : t_pulses
    task automatic t_regacc();
        logic [7:0] c [9] = '{8'hD0, 8'hFF, 8'hC0, 8'hCA, 8'h90, 8'hA6,
                              8'h8A, 8'h8C, 8'hAD};
        logic [8:0] e [9] = '{9'h040, 9'h06F, 9'h080, 9'h08A, 9'h180,
                              9'h196, 9'h18A, 9'h18C, 9'h18C};
        for (int i = 0; i < 9; i++) begin
            cmdw(c[i]);
            chk(s, {12'h0, i < 8});
            chk({accw, acck, acci}, e[i]);
        end
    endtask : t_regacc
    task automatic t_erc_irq();
        cmdw(CMD_DEV_ON);
        chk({dev, cnd}, {1'b1, CND_ERC_WAIT});
        cmdw(CMD_DEV_OFF);
        chk({dev, cnd}, {1'b0, CND_IDLE});
        raise();
        cmdw(CMD_EVT_CLR);
        chk({erf, evf}, 2'b10);
        cmdw(CMD_ERR_CLR);
        bus(OFS_STATUS, 1'b0, 32'h0);
        chk(q[5:0], 6'h00);
    endtask : t_erc_irq
    task automatic t_soft_reset_cmd();
        cmdw(CMD_OUT_SET + 8'h03);
        raise();
        cmdw(CMD_SOFT_RESET_CMD);
        chk(s, 13'h1000);
        repeat (SOFT_RESET_CMD_CYC - 5) @(posedge clk_i); // host stays quiet
        chk({evf, out_pin_o}, {1'b0, OUT_RST});
        bus(OFS_PINCFG, 1'b0, 32'h0);
        chk(q, {24'h0, PINCFG_RST});
    endtask : t_soft_reset_cmd
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        bus(OFS_OUTPUT, 1'b0, 32'h0);
        chk(q, {24'h0, OUT_RST});
        @(posedge clk_i);
        bus(4'h2, 1'b0, 32'h0); // unmapped offset reads as zero
        chk(q, 32'h0);
        t_pins();
        t_oneshot();
        t_pulses();
        t_regacc();
        t_erc_irq();
        t_soft_reset_cmd();
        close_out();
    end
    // roughly ten times the expected run length
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule : mccd_top_test
